/* verilog/cis_pkg.sv */
package cis_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYC =
        (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned DLY_W = 24;
    localparam int unsigned TICK_W = 20;
    localparam int unsigned IRQ_W = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] ACT_DLY_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] START_DLY_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] DET_DLY_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] RESTART_DLY_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h1C;
    localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 8'h20;
    localparam logic [ADDR_W-1:0] CMD_OFS = 8'h24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_POL_BIT = 0;
    localparam int unsigned CTRL_REACT_LSB = 1;
    localparam int unsigned CTRL_RESTART_BIT = 3;
    localparam int unsigned CMD_RESET_BIT = 0;
    localparam int unsigned CMD_ACK_BIT = 1;
    localparam int unsigned ST_RAW_BIT = 0;
    localparam int unsigned ST_ACTIVE_BIT = 1;
    localparam int unsigned ST_START_BIT = 2;
    localparam int unsigned ST_ALARM_BIT = 3;
    localparam int unsigned ST_SHUT_BIT = 4;
    localparam int unsigned IRQ_ACTIVE_BIT = 0;
    localparam int unsigned IRQ_ALARM_BIT = 1;
    localparam int unsigned IRQ_SHUT_BIT = 2;
    localparam int unsigned IRQ_AUTO_BIT = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {CIS_POL_OPEN, CIS_POL_CLOSED} cis_pol_t;
    typedef enum logic [1:0] {
        CIS_REACT_OFF,
        CIS_REACT_ALARM,
        CIS_REACT_SHUT
    } cis_react_t;
    typedef enum logic {CIS_RESTART_MANUAL, CIS_RESTART_TIMED} cis_restart_t;

    typedef struct packed {
        cis_pol_t pol;
        cis_react_t react;
        cis_restart_t restart;
        logic [DLY_W-1:0] act_dly;
        logic [DLY_W-1:0] start_dly;
        logic [DLY_W-1:0] det_dly;
        logic [DLY_W-1:0] restart_dly;
    } cis_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cis_bus_req_t;

    typedef struct packed {
        logic input_active;
        logic alarm;
        logic shutdown;
    } cis_evt_out_t;

    // ------------------------------------------------------------
    // Reset values, delays in ticks
    // ------------------------------------------------------------
    localparam logic [DLY_W-1:0] ACT_DLY_RST = 24'h000000;
    localparam logic [DLY_W-1:0] START_DLY_RST = 24'h0003E8;
    localparam logic [DLY_W-1:0] DET_DLY_RST = 24'h0003E8;
    localparam logic [DLY_W-1:0] RESTART_DLY_RST = 24'h00EA60;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;
    localparam cis_cfg_t CFG_RST = '{
        pol: CIS_POL_CLOSED,
        react: CIS_REACT_OFF,
        restart: CIS_RESTART_MANUAL,
        act_dly: ACT_DLY_RST,
        start_dly: START_DLY_RST,
        det_dly: DET_DLY_RST,
        restart_dly: RESTART_DLY_RST
    };

endpackage

/* verilog/cis_dly_timer.sv */
`timescale 1ns/10ps

module cis_dly_timer (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    input wire logic [cis_pkg::DLY_W-1:0] limit,
    output logic done
);

    typedef struct packed {
        logic [cis_pkg::DLY_W-1:0] cnt;
    } cis_tmr_st_t;

    cis_tmr_st_t q;
    cis_tmr_st_t d;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Counts whole ticks, so a delay is quantised to the tick period
    always_comb begin
        d = q;
        if (!run) begin
            d.cnt = '0;
        end else if (tick && (q.cnt < limit)) begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    assign done = run && (q.cnt >= limit);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_timer_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        !run |=> (q.cnt == '0))
        else $error("timer kept its count after run dropped");

endmodule // cis_dly_timer

/* verilog/cis_supervisor.sv */
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps

// Behaviour
// - With open polarity the input counts as active when the contact is open.
// - With closed polarity the input counts as active when it is closed.
// - The input is flagged active only after the full active delay.
// - With reaction off the input raises neither alarm nor shutdown.
// - With reaction alarm a qualified condition raises an alarm only.
// - With reaction shutdown a qualified condition requests a stop.
// - No condition is examined for alarm or shutdown until the pump has run for the start delay.
// - The start delay is applied once per system start.
// - After the start delay the detection delay qualifies conditions.
// - An event needs the condition unbroken for the full detection delay.
// - With manual restart a shutdown stays latched until operator reset.
// - With timed restart a shutdown clears after the restart delay.
// - The restart timer runs only for timed restart; its expiry clears it.

module cis_supervisor #(
    parameter int unsigned TICK_CYCLES = cis_pkg::TICK_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic contact_in,
    input wire logic pump_running,
    input wire logic sys_start,
    input wire cis_pkg::cis_bus_req_t bus_req,
    output logic [cis_pkg::DATA_W-1:0] rd_data,
    output cis_pkg::cis_evt_out_t evt_out,
    output logic irq
);

    // A tick period wider than the counter is cut, so keep it in range
    localparam int unsigned TICK_LAST_I = TICK_CYCLES - 1;
    localparam logic [cis_pkg::TICK_W-1:0] TICK_LAST =
        TICK_LAST_I[cis_pkg::TICK_W-1:0];

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [cis_pkg::TICK_W-1:0] tick_cnt;
        logic tick;
        cis_pkg::cis_cfg_t cfg;
        logic active;
        logic start_done;
        logic det_seen;
        logic alarm;
        logic shut;
        logic [cis_pkg::IRQ_W-1:0] irq_stat;
        logic [cis_pkg::IRQ_W-1:0] irq_en;
        logic irq;
        logic [cis_pkg::DATA_W-1:0] rd_data;
    } cis_top_st_t;

    cis_top_st_t q;
    cis_top_st_t d;

    logic act_raw;
    logic deb_done;
    logic st_run;
    logic st_done;
    logic det_run;
    logic det_done;
    logic det_fire;
    logic rs_run;
    logic rs_done;
    logic alarm_set;
    logic shut_set;
    logic op_reset;
    logic op_ack;
    logic react_on;
    logic [cis_pkg::IRQ_W-1:0] irq_clr;
    logic [cis_pkg::IRQ_W-1:0] irq_ev;

    // ------------------------------------------------------------
    // Qualification
    // ------------------------------------------------------------
    // Contact is high when closed
    assign act_raw = (q.cfg.pol == cis_pkg::CIS_POL_CLOSED) ? q.sync2
                                                              : ~q.sync2;
    assign react_on = (q.cfg.react == cis_pkg::CIS_REACT_ALARM) ||
                      (q.cfg.react == cis_pkg::CIS_REACT_SHUT);
    // A system start restarts the start delay even while the pump runs
    assign st_run = pump_running && !q.start_done && !sys_start;
    assign det_run = q.active && q.start_done && react_on;
    assign det_fire = det_done && !q.det_seen;
    assign alarm_set = det_fire &&
                       (q.cfg.react == cis_pkg::CIS_REACT_ALARM);
    assign shut_set = det_fire &&
                      (q.cfg.react == cis_pkg::CIS_REACT_SHUT);
    assign rs_run = q.shut &&
                    (q.cfg.restart == cis_pkg::CIS_RESTART_TIMED);

    assign op_reset = bus_req.wr && (bus_req.addr == cis_pkg::CMD_OFS) &&
                      bus_req.wdata[cis_pkg::CMD_RESET_BIT];
    assign op_ack = bus_req.wr && (bus_req.addr == cis_pkg::CMD_OFS) &&
                    bus_req.wdata[cis_pkg::CMD_ACK_BIT];
    assign irq_clr = (bus_req.wr && (bus_req.addr == cis_pkg::IRQ_CLR_OFS))
                   ? bus_req.wdata[cis_pkg::IRQ_W-1:0] : '0;

    always_comb begin
        irq_ev = '0;
        irq_ev[cis_pkg::IRQ_ACTIVE_BIT] = deb_done && !q.active;
        irq_ev[cis_pkg::IRQ_ALARM_BIT] = alarm_set;
        irq_ev[cis_pkg::IRQ_SHUT_BIT] = shut_set;
        irq_ev[cis_pkg::IRQ_AUTO_BIT] = rs_done;
    end

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    cis_dly_timer u_debounce (
        .core_clk(core_clk),
        .rst(rst),
        .tick(q.tick),
        .run(act_raw),
        .limit(q.cfg.act_dly),
        .done(deb_done)
    );

    cis_dly_timer u_start (
        .core_clk(core_clk),
        .rst(rst),
        .tick(q.tick),
        .run(st_run),
        .limit(q.cfg.start_dly),
        .done(st_done)
    );

    cis_dly_timer u_detect (
        .core_clk(core_clk),
        .rst(rst),
        .tick(q.tick),
        .run(det_run),
        .limit(q.cfg.det_dly),
        .done(det_done)
    );

    cis_dly_timer u_restart (
        .core_clk(core_clk),
        .rst(rst),
        .tick(q.tick),
        .run(rs_run),
        .limit(q.cfg.restart_dly),
        .done(rs_done)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.sync1 = contact_in;
        d.sync2 = q.sync1;
        d.tick = 1'b0;
        if (q.tick_cnt >= TICK_LAST) begin
            d.tick_cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 1'b1;
        end
        d.active = deb_done;
        if (sys_start) begin
            d.start_done = 1'b0;
        end else if (st_done) begin
            d.start_done = 1'b1;
        end
        // One event per unbroken condition, not one per cycle
        d.det_seen = det_run && (q.det_seen || det_done);
        // Set wins over a clear in the same cycle
        d.alarm = alarm_set || (q.alarm && !op_ack);
        d.shut = shut_set || (q.shut && !op_reset && !rs_done);
        d.irq_stat = irq_ev | (q.irq_stat & ~irq_clr);
        if (bus_req.wr) begin
            if (bus_req.addr == cis_pkg::CTRL_OFS) begin
                d.cfg.pol = cis_pkg::cis_pol_t'(
                    bus_req.wdata[cis_pkg::CTRL_POL_BIT]);
                d.cfg.react = cis_pkg::cis_react_t'(
                    bus_req.wdata[cis_pkg::CTRL_REACT_LSB +: 2]);
                d.cfg.restart = cis_pkg::cis_restart_t'(
                    bus_req.wdata[cis_pkg::CTRL_RESTART_BIT]);
            end else if (bus_req.addr == cis_pkg::ACT_DLY_OFS) begin
                d.cfg.act_dly = bus_req.wdata[cis_pkg::DLY_W-1:0];
            end else if (bus_req.addr == cis_pkg::START_DLY_OFS) begin
                d.cfg.start_dly = bus_req.wdata[cis_pkg::DLY_W-1:0];
            end else if (bus_req.addr == cis_pkg::DET_DLY_OFS) begin
                d.cfg.det_dly = bus_req.wdata[cis_pkg::DLY_W-1:0];
            end else if (bus_req.addr == cis_pkg::RESTART_DLY_OFS) begin
                d.cfg.restart_dly = bus_req.wdata[cis_pkg::DLY_W-1:0];
            end else if (bus_req.addr == cis_pkg::IRQ_EN_OFS) begin
                d.irq_en = bus_req.wdata[cis_pkg::IRQ_W-1:0];
            end
        end
        d.irq = |(d.irq_stat & d.irq_en);
        // Read data stand for one cycle only, zero otherwise
        d.rd_data = '0;
        if (bus_req.rd) begin
            if (bus_req.addr == cis_pkg::CTRL_OFS) begin
                d.rd_data[cis_pkg::CTRL_POL_BIT] = q.cfg.pol;
                d.rd_data[cis_pkg::CTRL_REACT_LSB +: 2] = q.cfg.react;
                d.rd_data[cis_pkg::CTRL_RESTART_BIT] = q.cfg.restart;
            end else if (bus_req.addr == cis_pkg::ACT_DLY_OFS) begin
                d.rd_data[cis_pkg::DLY_W-1:0] = q.cfg.act_dly;
            end else if (bus_req.addr == cis_pkg::START_DLY_OFS) begin
                d.rd_data[cis_pkg::DLY_W-1:0] = q.cfg.start_dly;
            end else if (bus_req.addr == cis_pkg::DET_DLY_OFS) begin
                d.rd_data[cis_pkg::DLY_W-1:0] = q.cfg.det_dly;
            end else if (bus_req.addr == cis_pkg::RESTART_DLY_OFS) begin
                d.rd_data[cis_pkg::DLY_W-1:0] = q.cfg.restart_dly;
            end else if (bus_req.addr == cis_pkg::STATUS_OFS) begin
                d.rd_data[cis_pkg::ST_RAW_BIT] = q.sync2;
                d.rd_data[cis_pkg::ST_ACTIVE_BIT] = q.active;
                d.rd_data[cis_pkg::ST_START_BIT] = q.start_done;
                d.rd_data[cis_pkg::ST_ALARM_BIT] = q.alarm;
                d.rd_data[cis_pkg::ST_SHUT_BIT] = q.shut;
            end else if (bus_req.addr == cis_pkg::IRQ_STAT_OFS) begin
                d.rd_data[cis_pkg::IRQ_W-1:0] = q.irq_stat;
            end else if (bus_req.addr == cis_pkg::IRQ_EN_OFS) begin
                d.rd_data[cis_pkg::IRQ_W-1:0] = q.irq_en;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
            q.cfg <= cis_pkg::CFG_RST;
            q.irq_en <= cis_pkg::IRQ_EN_RST;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd_data;
    assign irq = q.irq;
    assign evt_out = '{input_active: q.active, alarm: q.alarm,
                       shutdown: q.shut};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_open_polarity: assert property (
        @(posedge core_clk) disable iff (rst)
        (q.cfg.pol == cis_pkg::CIS_POL_OPEN && q.sync2) |=> !q.active)
        else $error("closed contact flagged active under open polarity");

    a_closed_polarity: assert property (
        @(posedge core_clk) disable iff (rst)
        (q.cfg.pol == cis_pkg::CIS_POL_CLOSED && !q.sync2) |=> !q.active)
        else $error("open contact flagged active under closed polarity");

    a_debounce_cause: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(q.active) |-> $past(act_raw))
        else $error("input flagged active without an active contact");

    a_disabled_quiet: assert property (
        @(posedge core_clk) disable iff (rst)
        !react_on |-> ##1 !$rose(q.alarm) && !$rose(q.shut))
        else $error("event raised while reaction is off");

    a_alarm_event: assert property (
        @(posedge core_clk) disable iff (rst)
        alarm_set |=> q.alarm && q.irq_stat[cis_pkg::IRQ_ALARM_BIT]
                      && !$rose(q.shut))
        else $error("alarm reaction did not raise alarm alone");

    a_shutdown_event: assert property (
        @(posedge core_clk) disable iff (rst)
        shut_set |=> q.shut && evt_out.shutdown)
        else $error("shutdown reaction did not raise shutdown");

    a_start_gate: assert property (
        @(posedge core_clk) disable iff (rst)
        (!q.start_done) |=> !$rose(q.alarm) && !$rose(q.shut))
        else $error("event raised before start delay ended");

    a_start_once: assert property (
        @(posedge core_clk) disable iff (rst)
        (q.start_done && !sys_start) |=> q.start_done)
        else $error("start delay applied twice in one run");

    a_detect_persist: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(q.alarm) |-> $past(q.active) && $past(q.start_done))
        else $error("alarm raised without a qualified condition");

    a_manual_latch: assert property (
        @(posedge core_clk) disable iff (rst)
        (q.shut && q.cfg.restart == cis_pkg::CIS_RESTART_MANUAL
         && !op_reset) |=> q.shut)
        else $error("manual shutdown cleared without operator reset");

    a_timed_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        (rs_done && !shut_set) |=> !q.shut
                                  && q.irq_stat[cis_pkg::IRQ_AUTO_BIT])
        else $error("timed restart did not clear shutdown");

    a_restart_scope: assert property (
        @(posedge core_clk) disable iff (rst)
        (q.cfg.restart == cis_pkg::CIS_RESTART_MANUAL) |-> !rs_done)
        else $error("restart timer expired under manual restart");

    a_irq_level: assert property (
        @(posedge core_clk) disable iff (rst)
        ##1 (q.irq == |($past(d.irq_stat) & $past(d.irq_en))))
        else $error("interrupt output disagrees with enabled status");

    a_open_active: assert property (
        @(posedge core_clk) disable iff (rst)
        (q.cfg.pol == cis_pkg::CIS_POL_OPEN && !q.sync2
         && q.cfg.act_dly == '0) |=> q.active)
        else $error("open contact not flagged active under open polarity");

    a_break_drops: assert property (
        @(posedge core_clk) disable iff (rst)
        !act_raw |=> !q.active)
        else $error("active flag kept after the contact went inactive");

    a_break_quiet: assert property (
        @(posedge core_clk) disable iff (rst)
        !q.active |=> !$rose(q.alarm) && !$rose(q.shut))
        else $error("event raised without an active condition");

    a_start_rearm: assert property (
        @(posedge core_clk) disable iff (rst)
        sys_start |=> !q.start_done)
        else $error("system start did not rearm the start delay");

    a_detect_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        (det_run && !q.det_seen && q.cfg.det_dly == '0
         && q.cfg.react == cis_pkg::CIS_REACT_ALARM) |=> q.alarm)
        else $error("zero detection delay did not raise the alarm");

    a_read_idle: assert property (
        @(posedge core_clk) disable iff (rst)
        !bus_req.rd |=> (q.rd_data == '0))
        else $error("read data stood outside their cycle");

    a_tick_phase: assert property (
        @(posedge core_clk) disable iff (rst)
        q.tick |-> (q.tick_cnt == '0))
        else $error("tick pulse out of step with its counter");

endmodule // cis_supervisor

/* verification/cis_contact_model.sv */
`timescale 1ns/10ps

// ------------------------------------------------------------
// Field contact that chatters before it settles
// ------------------------------------------------------------
module cis_contact_model (
    input wire logic core_clk,
    input wire logic closed_cmd,
    input wire logic [3:0] bounce_n,
    output logic contact_in
);
    logic last_q;
    logic [3:0] bnc_q;

    initial begin
        contact_in = 1'b0;
        last_q = 1'b0;
        bnc_q = 4'h0;
    end

    // One flip per cycle, so no debounce window above zero can ever be met early
    always @(posedge core_clk) begin
        if (closed_cmd !== last_q) begin
            last_q <= closed_cmd;
            bnc_q <= bounce_n;
            contact_in <= ~contact_in;
        end else if (bnc_q != 4'h0) begin
            bnc_q <= bnc_q - 4'h1;
            contact_in <= ~contact_in;
        end else begin
            contact_in <= last_q;
        end
    end
endmodule // cis_contact_model

/* verification/cis_supervisor_tb.sv */
`timescale 1ns/10ps

module cis_supervisor_tb;
    typedef struct packed {
        logic pol;
        logic [1:0] react;
        logic closed;
        logic [2:0] exp;
    } cis_row_t;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] v;
    } cis_reg_t;

    logic core_clk, rst, contact_in, pump_running, sys_start, irq;
    logic closed_cmd;
    logic [3:0] bounce_n;
    cis_pkg::cis_bus_req_t bus_req;
    logic [31:0] rd_data, d;
    cis_pkg::cis_evt_out_t evt_out;
    logic [2:0] ev;
    int num_errors, tests_run;

    assign ev = evt_out;

    // Ticks of 4 cycles keep every delay short
    cis_supervisor #(.TICK_CYCLES(4)) cis_supervisor_i (
        .core_clk(core_clk), .rst(rst), .contact_in(contact_in),
        .pump_running(pump_running), .sys_start(sys_start),
        .bus_req(bus_req), .rd_data(rd_data), .evt_out(evt_out),
        .irq(irq));
    cis_contact_model cis_contact_model_i (
        .core_clk(core_clk), .closed_cmd(closed_cmd),
        .bounce_n(bounce_n), .contact_in(contact_in));

    // ------------------------------------------------------------
    // Tables: pol, react, contact closed, {active, alarm, shutdown}
    // ------------------------------------------------------------
    cis_row_t rows [6] = '{
        '{1'b0, 2'h1, 1'b0, 3'h6}, '{1'b0, 2'h1, 1'b1, 3'h0},
        '{1'b1, 2'h1, 1'b1, 3'h6}, '{1'b1, 2'h0, 1'b1, 3'h4},
        '{1'b1, 2'h2, 1'b1, 3'h5}, '{1'b1, 2'h3, 1'b1, 3'h4}};
    cis_reg_t rst_vals [11] = '{
        '{8'h00, 32'h1}, '{8'h04, 32'h0}, '{8'h08, 32'h3E8},
        '{8'h0C, 32'h3E8}, '{8'h10, 32'hEA60}, '{8'h14, 32'h0},
        '{8'h18, 32'h0}, '{8'h1C, 32'h0}, '{8'h20, 32'h0},
        '{8'h24, 32'h0}, '{8'h30, 32'h0}};

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task report_and_stop();
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        v = rd_data;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task wait_bit(input int i, input logic v, input int lim);
        int n;
        n = 0;
        while (ev[i] !== v && n < lim) begin
            cyc(1);
            n++;
        end
        chk({31'h0, ev[i]}, {31'h0, v});
        if (ev[i] !== v) report_and_stop();
    endtask

    task sys_pulse();
        @(posedge core_clk);
        sys_start <= 1'b1;
        @(posedge core_clk);
        sys_start <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        num_errors = 0;
        tests_run = 0;
        rst = 1'b1;
        pump_running = 1'b1;
        sys_start = 1'b0;
        closed_cmd = 1'b0;
        bounce_n = 4'h0;
        bus_req = '0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        cyc(1);
        chk({28'h0, ev, irq}, 32'h0);
        foreach (rst_vals[k]) begin
            rd(rst_vals[k].a, d);
            chk(d, rst_vals[k].v);
        end
        wr(cis_pkg::START_DLY_OFS, 32'h0);
        wr(cis_pkg::DET_DLY_OFS, 32'h0);
        foreach (rows[k]) begin
            wr(cis_pkg::CTRL_OFS, {29'h0, rows[k].react, rows[k].pol});
            sys_pulse();
            closed_cmd <= rows[k].closed;
            cyc(30);
            chk({29'h0, ev}, {29'h0, rows[k].exp});
            closed_cmd <= ~rows[k].pol;
            cyc(6);
            wr(cis_pkg::CMD_OFS, 32'h3);
            cyc(4);
        end
        // Chatter longer than nothing, shorter than the debounce
        wr(cis_pkg::ACT_DLY_OFS, 32'h4);
        bounce_n <= 4'hC;
        closed_cmd <= 1'b1;
        cyc(25);
        chk({31'h0, ev[2]}, 32'h0);
        wait_bit(2, 1'b1, 40);
        bounce_n <= 4'h0;
        closed_cmd <= 1'b0;
        wait_bit(2, 1'b0, 8);
        wr(cis_pkg::ACT_DLY_OFS, 32'h0);
        // Start delay, detection delay and the interrupt path
        wr(cis_pkg::CTRL_OFS, 32'h3);
        wr(cis_pkg::START_DLY_OFS, 32'h5);
        wr(cis_pkg::DET_DLY_OFS, 32'h2);
        wr(cis_pkg::IRQ_CLR_OFS, 32'hF);
        wr(cis_pkg::IRQ_EN_OFS, 32'h2);
        pump_running <= 1'b0;
        sys_pulse();
        closed_cmd <= 1'b1;
        pump_running <= 1'b1;
        cyc(12);
        chk({31'h0, ev[1]}, 32'h0);
        wait_bit(1, 1'b1, 60);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        rd(cis_pkg::IRQ_STAT_OFS, d);
        chk(d, 32'h3);
        wr(cis_pkg::IRQ_EN_OFS, 32'h0);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(cis_pkg::IRQ_CLR_OFS, 32'hF);
        rd(cis_pkg::IRQ_STAT_OFS, d);
        chk(d, 32'h0);
        closed_cmd <= 1'b0;
        wr(cis_pkg::CMD_OFS, 32'h2);
        cyc(6);
        closed_cmd <= 1'b1;
        cyc(5);
        chk({31'h0, ev[1]}, 32'h0);
        wait_bit(1, 1'b1, 16);
        closed_cmd <= 1'b0;
        wr(cis_pkg::CMD_OFS, 32'h2);
        // Manual restart holds, operator reset releases
        wr(cis_pkg::DET_DLY_OFS, 32'h0);
        wr(cis_pkg::RESTART_DLY_OFS, 32'h3);
        wr(cis_pkg::CTRL_OFS, 32'h5);
        closed_cmd <= 1'b1;
        wait_bit(0, 1'b1, 20);
        closed_cmd <= 1'b0;
        cyc(40);
        chk({31'h0, ev[0]}, 32'h1);
        wr(cis_pkg::CMD_OFS, 32'h1);
        cyc(2);
        chk({31'h0, ev[0]}, 32'h0);
        // Timed restart clears on its own
        wr(cis_pkg::CTRL_OFS, 32'hD);
        wr(cis_pkg::IRQ_CLR_OFS, 32'hF);
        closed_cmd <= 1'b1;
        wait_bit(0, 1'b1, 20);
        closed_cmd <= 1'b0;
        cyc(5);
        chk({31'h0, ev[0]}, 32'h1);
        wait_bit(0, 1'b0, 20);
        rd(cis_pkg::IRQ_STAT_OFS, d);
        chk(d, 32'hD);
        report_and_stop();
    end
endmodule // cis_supervisor_tb
